// >>> hw/mmd_pkg.sv
// mmd_pkg: constants for the memory map decoder around the 8-bit core.
// assumes: one core clock domain; all users refer to names as mmd_pkg::name.
package mmd_pkg;

    // ****************************************************************
    // machine cycle
    // ****************************************************************
    localparam int unsigned STATES_PER_MC = 6;

    // ****************************************************************
    // internal data space
    // ****************************************************************
    localparam logic [7:0] INTERNAL_DATA_SPACE_UPPER_BASE = 8'h80;   // first sfr / upper ram address
    localparam int unsigned INTERNAL_DATA_SPACE_HI_BIT    = 7;

    // ****************************************************************
    // extended data space
    // ****************************************************************
    localparam logic [15:0] EXTENDED_DATA_SPACE_RAM_LAST   = 16'h02FF;
    localparam logic [15:0] EXTENDED_DATA_SPACE_RAM_END    = 16'h5FFF;
    localparam logic [15:0] EXTENDED_DATA_SPACE_PERI_BASE  = 16'h6000;
    localparam logic [15:0] EXTENDED_DATA_SPACE_PERI_END   = 16'h7FFF;
    localparam logic [7:0]  PERI_REGION_IO  = 8'h61;
    localparam logic [7:0]  PERI_REGION_PCR = 8'h62;
    localparam logic [7:0]  PERI_REGION_CL  = 8'h63;
    localparam logic [7:0]  CL_LAST_LOW     = 8'h3F;    // contactless ends at 633Fh
    localparam int unsigned PERI_REGIONS    = 32;

    // ****************************************************************
    // program memory
    // ****************************************************************
    localparam logic [15:0] ROM_LAST = 16'h9FFF;

    // ****************************************************************
    // power control and page registers
    // ****************************************************************
    localparam logic [7:0] PWR_CTRL_ADDR  = 8'h87;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
    localparam logic [7:0] PWR_CTRL_WMASK = 8'h83;      // bits 7,1,0 writable
    localparam int unsigned BAUD_DBL_BIT  = 7;
    localparam int unsigned PWR_DOWN_BIT  = 1;
    localparam logic [7:0] PAGE_REG_ADDR  = 8'hFA;      // page register in sfr map
    localparam logic [7:0] PAGE_REG_RESET = 8'h00;

    // ****************************************************************
    // targets
    // ****************************************************************
    typedef enum logic [2:0] {
        MMD_DT_LOWER = 3'h0,
        MMD_DT_UPPER = 3'h1,
        MMD_DT_SFR   = 3'h2
    } mmd_dtgt_e;

    typedef enum logic [2:0] {
        MMD_XT_NONE = 3'h0,
        MMD_XT_RAM  = 3'h1,
        MMD_XT_IO   = 3'h2,
        MMD_XT_PCR  = 3'h3,
        MMD_XT_CL   = 3'h4
    } mmd_xtgt_e;

endpackage : mmd_pkg

// >>> hw/mmd_decoder.sv
// mmd_decoder: address decode for internal, extended and program spaces,
// machine-cycle state sequencer, power control and page registers.
// assumes: core drives one access request per cycle on ref_clk; memories and
// peripherals sit outside and follow the select outputs.
// assumes: selects and read data are combinational, so the core samples
// them in the same cycle; register writes show one cycle later.
// assumes: only reset leaves power down; no wake-up path lives here.

`timescale 1ns/1ps

module mmd_decoder #(
    parameter int unsigned ADDR_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // internal data space access
    input  wire logic              id_req,
    input  wire logic              id_indirect,
    input  wire logic [7:0]        id_field,
    input  wire logic [7:0]        id_reg_val,
    input  wire logic              id_we,
    input  wire logic [7:0]        id_wdata,
    output logic                   id_lower_sel,
    output logic                   id_upper_sel,
    output logic                   id_sfr_sel,
    output logic [7:0]             id_addr,
    output logic [7:0]             sfr_rdata,
    output logic                   sfr_hit,
    // extended data space access
    input  wire logic              x_req,
    input  wire logic              x_paged,
    input  wire logic              x_we,
    input  wire logic [ADDR_W-1:0] data_pointer_reg,
    input  wire logic [7:0]        x_ptr_reg,
    input  wire logic [7:0]        x_wdata,
    input  wire logic [7:0]        x_rdata_in,
    output logic [ADDR_W-1:0]      x_addr,
    output logic                   x_ram_sel,
    output logic                   x_io_sel,
    output logic                   x_pcr_sel,
    output logic                   x_cl_sel,
    output logic                   x_we_out,
    output logic [7:0]             x_wdata_out,
    output logic [7:0]             x_rdata,
    output logic [4:0]             x_region,
    // program memory
    input  wire logic [ADDR_W-1:0] pc_addr,
    output logic                   rom_sel,
    output logic [ADDR_W-1:0]      rom_addr,
    // machine cycle and power
    output logic [5:0]             clk_state,
    output logic                   mc_start,
    output logic                   debug_baud_double,
    output logic                   cpu_power_down
);

    // ****************************************************************
    // machine cycle sequencer
    // ****************************************************************
    // one-hot ring of six states; the default arm below catches any
    // corrupted code and restarts the cycle at S1
    typedef enum logic [5:0] {
        MMD_S1 = 6'h01,
        MMD_S2 = 6'h02,
        MMD_S3 = 6'h04,
        MMD_S4 = 6'h08,
        MMD_S5 = 6'h10,
        MMD_S6 = 6'h20
    } mmd_state_e;

    // clk_state shows the ring directly, one flop per state
    mmd_state_e st_q;
    mmd_state_e st_d;

    always_comb begin
        unique case (st_q)
            MMD_S1: st_d = MMD_S2;
            MMD_S2: st_d = MMD_S3;
            MMD_S3: st_d = MMD_S4;
            MMD_S4: st_d = MMD_S5;
            MMD_S5: st_d = MMD_S6;
            MMD_S6: st_d = MMD_S1;
            default: st_d = MMD_S1;   // recover from an illegal code
        endcase
        // finish the running machine cycle first, so the instruction
        // that set power down is never cut short; only then park in S1
        // and stay there until reset
        if (cpu_power_down && (st_q == MMD_S1)) begin
            st_d = MMD_S1;            // core frozen while powered down
        end
    end

    // state register, reset parks the ring in S1
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= MMD_S1;
        end else begin
            st_q <= st_d;
        end
    end

    // mc_start marks S1 of a running cycle; it stays low while parked,
    // so nothing downstream starts a new instruction in power down
    assign clk_state = st_q;
    assign mc_start  = (st_q == MMD_S1) && !cpu_power_down;

    // ****************************************************************
    // internal data space decode
    // ****************************************************************
    // effective address and its top bit pick the block
    logic [7:0] id_eff;
    logic       id_hi;

    assign id_eff  = id_indirect ? id_reg_val : id_field;
    assign id_hi   = id_eff[mmd_pkg::INTERNAL_DATA_SPACE_HI_BIT];
    // not registered, so the ram sees the address in the access cycle
    assign id_addr = id_eff;

    // at most one select per request, chosen by address half and mode
    always_comb begin
        id_lower_sel = 1'b0;
        id_upper_sel = 1'b0;
        id_sfr_sel   = 1'b0;
        if (id_req) begin
            if (!id_hi) begin
                id_lower_sel = 1'b1;
            end else if (id_indirect) begin
                id_upper_sel = 1'b1;
            end else begin
                id_sfr_sel = 1'b1;
            end
        end
    end

    // ****************************************************************
    // sfr block: power control and page register
    // ****************************************************************
    // only power control and the page register live in this block;
    // every other sfr address is answered by logic outside
    logic [7:0] pwr_q;
    logic [7:0] pwr_d;
    logic [7:0] page_q;
    logic [7:0] page_d;
    logic       pwr_hit;
    logic       page_hit;

    // a hit needs a direct access, so indirect 87h reaches upper ram
    assign pwr_hit  = id_sfr_sel && (id_eff == mmd_pkg::PWR_CTRL_ADDR);
    assign page_hit = id_sfr_sel && (id_eff == mmd_pkg::PAGE_REG_ADDR);
    assign sfr_hit  = pwr_hit || page_hit;

    // read-only reserved bits stay zero through the write mask
    always_comb begin
        pwr_d  = pwr_q;
        page_d = page_q;
        if (pwr_hit && id_we) begin
            // bit 0 stored as written, software keeps it low
            pwr_d = id_wdata & mmd_pkg::PWR_CTRL_WMASK;
        end
        // page register keeps all eight bits as written
        if (page_hit && id_we) begin
            page_d = id_wdata;
        end
    end

    // sfr registers, both cleared by reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_q  <= mmd_pkg::PWR_CTRL_RESET;
            page_q <= mmd_pkg::PAGE_REG_RESET;
        end else begin
            pwr_q  <= pwr_d;
            page_q <= page_d;
        end
    end

    // power control reads back its masked copy, page register all bits
    // sfr read mux, unknown sfrs read zero here (other blocks answer them)
    always_comb begin
        if (pwr_hit) begin
            sfr_rdata = pwr_q;
        end else if (page_hit) begin
            sfr_rdata = page_q;
        end else begin
            sfr_rdata = 8'h00;
        end
    end

    // both flags come straight from flops, so they never glitch
    // baud doubling bit
    assign debug_baud_double = pwr_q[mmd_pkg::BAUD_DBL_BIT];
    assign cpu_power_down    = pwr_q[mmd_pkg::PWR_DOWN_BIT];

    // ****************************************************************
    // extended data space decode
    // ****************************************************************
    // paged and pointer accesses share one decoder behind the mux,
    // so both reach exactly the same targets
    logic [ADDR_W-1:0] xa;
    logic              in_ram;
    logic              in_peri;
    logic [7:0]        xhi;
    logic [7:0]        xlo;
    mmd_pkg::mmd_xtgt_e xt;

    assign xa  = x_paged ? {page_q, x_ptr_reg} : data_pointer_reg;
    assign xhi = xa[15:8];
    assign xlo = xa[7:0];

    // ram part, only low window valid
    assign in_ram  = (xa <= mmd_pkg::EXTENDED_DATA_SPACE_RAM_LAST);
    assign in_peri = (xa >= mmd_pkg::EXTENDED_DATA_SPACE_PERI_BASE) &&
                     (xa <= mmd_pkg::EXTENDED_DATA_SPACE_PERI_END);

    // region table
    // first match wins; the ram test comes before the window, and 6000h
    // as well as everything above 633Fh falls through to none
    always_comb begin
        xt = mmd_pkg::MMD_XT_NONE;
        if (in_ram) begin
            xt = mmd_pkg::MMD_XT_RAM;
        end else if (in_peri) begin
            if (xhi == mmd_pkg::PERI_REGION_IO) begin
                xt = mmd_pkg::MMD_XT_IO;
            end else if (xhi == mmd_pkg::PERI_REGION_PCR) begin
                xt = mmd_pkg::MMD_XT_PCR;
            end else if (xhi == mmd_pkg::PERI_REGION_CL && xlo <= mmd_pkg::CL_LAST_LOW) begin
                xt = mmd_pkg::MMD_XT_CL;
            end
        end
    end

    // ****************************************************************
    // peripheral window regions
    // ****************************************************************
    // one hit line per 256-byte region of the window
    logic [mmd_pkg::PERI_REGIONS-1:0] region_hit;

    for (genvar g = 0; g < mmd_pkg::PERI_REGIONS; g++) begin : g_region
        assign region_hit[g] = in_peri && (xa[12:8] == 5'(g));
    end

    // region index also reports reserved regions; the selects ignore those
    always_comb begin
        x_region = 5'h00;
        for (int i = 0; i < mmd_pkg::PERI_REGIONS; i++) begin
            if (region_hit[i]) begin
                x_region = 5'(i);
            end
        end
    end

    // selects only rise with a request, so idle cycles touch nothing
    assign x_addr    = xa;
    assign x_ram_sel = x_req && (xt == mmd_pkg::MMD_XT_RAM);
    assign x_io_sel  = x_req && (xt == mmd_pkg::MMD_XT_IO);
    assign x_pcr_sel = x_req && (xt == mmd_pkg::MMD_XT_PCR);
    assign x_cl_sel  = x_req && (xt == mmd_pkg::MMD_XT_CL);

    // a hole must never see a write strobe, and a read from it must not
    // return whatever the idle peripheral bus happens to carry
    // reserved: no write strobe, zero read
    assign x_we_out    = x_req && x_we && (xt != mmd_pkg::MMD_XT_NONE);
    assign x_wdata_out = x_wdata;
    assign x_rdata     = (xt == mmd_pkg::MMD_XT_NONE) ? 8'h00 : x_rdata_in;

    // ****************************************************************
    // program memory
    // ****************************************************************
    // fetches above the rom range leave rom_sel low; nothing here answers
    // them, so the fetch side must treat them as empty
    // rom range
    assign rom_sel  = (pc_addr <= mmd_pkg::ROM_LAST);
    assign rom_addr = pc_addr;

endmodule : mmd_decoder

// >>> sim/mmd_decoder_assertions.sv
// checker: port-level properties of the memory map decoder
// assumes: bound to mmd_decoder, one clock, rst async active high
`timescale 1ns/1ps
module mmd_decoder_assertions #(
    parameter int unsigned ADDR_W = 16
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              id_req,
    input wire logic              id_indirect,
    input wire logic              id_we,
    input wire logic [7:0]        id_wdata,
    input wire logic              id_lower_sel,
    input wire logic              id_upper_sel,
    input wire logic              id_sfr_sel,
    input wire logic [7:0]        id_addr,
    input wire logic              x_req,
    input wire logic [ADDR_W-1:0] x_addr,
    input wire logic              x_ram_sel,
    input wire logic              x_we_out,
    input wire logic [7:0]        x_rdata,
    input wire logic [ADDR_W-1:0] pc_addr,
    input wire logic              rom_sel,
    input wire logic [5:0]        clk_state,
    input wire logic              debug_baud_double,
    input wire logic              cpu_power_down
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // power down may land mid-cycle, so the tail still runs to S1
    sequence s_mc_tail;
        clk_state == 6'h04 ##1 clk_state == 6'h08 ##1 clk_state == 6'h10
            ##1 clk_state == 6'h20 ##1 clk_state == 6'h01;
    endsequence
    sequence s_pwr_wr;
        id_req && id_we && id_sfr_sel && id_addr == 8'h87;
    endsequence
    property p_mc_six; clk_state == 6'h02 |=> s_mc_tail; endproperty
    a_mc_six: assert property (p_mc_six) else $error("machine cycle length");
    property p_lower; id_req && !id_addr[7] |-> id_lower_sel; endproperty
    a_lower: assert property (p_lower) else $error("lower ram not selected");
    property p_sfr; id_req && id_addr[7] && !id_indirect |-> id_sfr_sel; endproperty
    a_sfr: assert property (p_sfr) else $error("sfr not selected");
    property p_upper; id_req && id_addr[7] && id_indirect |-> id_upper_sel; endproperty
    a_upper: assert property (p_upper) else $error("upper ram not selected");
    property p_xgap;
        x_req && x_addr > 16'h02FF && x_addr < 16'h6000 |-> !x_ram_sel && !x_we_out
            && x_rdata == 8'h00;
    endproperty
    a_xgap: assert property (p_xgap) else $error("invalid ram range used");
    property p_rom; rom_sel == (pc_addr <= 16'h9FFF); endproperty
    a_rom: assert property (p_rom) else $error("rom select wrong");
    property p_baud; s_pwr_wr |=> debug_baud_double == $past(id_wdata[7]); endproperty
    a_baud: assert property (p_baud) else $error("baud double not written");
    property p_pd; s_pwr_wr and id_wdata[1] |=> cpu_power_down; endproperty
    a_pd: assert property (p_pd) else $error("power down not entered");
endmodule : mmd_decoder_assertions

// >>> sim/mmd_periph_model.sv
// peripheral side model: answers extended reads from the selected target
// assumes: selects and address come straight from the decoder
`timescale 1ns/1ps
module mmd_periph_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] x_addr,
    input  wire logic        x_ram_sel,
    input  wire logic        x_io_sel,
    input  wire logic        x_pcr_sel,
    input  wire logic        x_cl_sel,
    output logic [7:0]       x_rdata_in
);
    logic junk_q;
    // unselected bus toggles so a stale or passed-through value never reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) junk_q <= 1'b0;
        else junk_q <= ~junk_q;
    end
    assign x_rdata_in = (x_ram_sel | x_io_sel | x_pcr_sel | x_cl_sel) ?
                        x_addr[7:0] ^ 8'hA5 : {4{junk_q, ~junk_q}};
endmodule : mmd_periph_model

// >>> sim/mmd_decoder_tb.sv
// testbench: drives core-side accesses and judges selects and registers
// assumes: package, decoder, checker and peripheral model compiled first
`timescale 1ns/1ps
module mmd_decoder_tb;
    logic        ref_clk, rst, id_req, id_indirect, id_we, x_req, x_paged, x_we;
    logic [7:0]  id_field, id_reg_val, id_wdata, x_ptr_reg, x_wdata, x_rdata_in;
    logic [15:0] data_pointer_reg, pc_addr, x_addr, rom_addr;
    logic        id_lower_sel, id_upper_sel, id_sfr_sel, sfr_hit, x_ram_sel, x_io_sel;
    logic        x_pcr_sel, x_cl_sel, x_we_out, rom_sel, mc_start;
    logic        debug_baud_double, cpu_power_down;
    logic [7:0]  id_addr, sfr_rdata, x_rdata, x_wdata_out;
    logic [4:0]  x_region;
    logic [5:0]  clk_state;
    int          errors, n_compared, n;
    logic [7:0]  at[4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    logic [15:0] xa[12] = '{16'h0000, 16'h02FF, 16'h0300, 16'h5FFF, 16'h6000, 16'h6100,
                            16'h61FF, 16'h6200, 16'h6300, 16'h633F, 16'h6340, 16'hFFFF};
    logic [3:0]  xs[12] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h2, 4'h1, 4'h1,
                            4'h0, 4'h0};
    mmd_decoder i_dut (.*);
    mmd_periph_model i_periph (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // direct write to an sfr, then leave the address up so it reads back
    task automatic sfr_wr(input logic [7:0] adr, input logic [7:0] d);
        @(posedge ref_clk);
        id_req <= 1'b1;
        id_indirect <= 1'b0;
        id_we <= 1'b1;
        id_field <= adr;
        id_wdata <= d;
        @(posedge ref_clk);
        id_we <= 1'b0;
        #1;
    endtask : sfr_wr
    task automatic t_internal_data_space;
        logic [7:0] a;
        for (int k = 0; k < 8; k++) begin
            a = at[k%4];
            @(posedge ref_clk);
            id_req <= 1'b1;
            id_indirect <= k[2];
            id_field <= k[2] ? ~a : a;
            id_reg_val <= k[2] ? a : ~a;
            #1;
            check(id_addr, a);
            check({id_lower_sel, id_upper_sel, id_sfr_sel},
                  {!a[7], a[7] & k[2], a[7] & !k[2]});
        end
        $display("t_internal_data_space done");
    endtask : t_internal_data_space
    task automatic t_extended_data_space;
        for (int k = 0; k < 12; k++) begin
            @(posedge ref_clk);
            x_req <= 1'b1;
            x_we <= 1'b1;
            x_wdata <= 8'h5A;
            x_paged <= 1'b0;
            data_pointer_reg <= xa[k];
            #1;
            check(x_addr, xa[k]);
            check({x_ram_sel, x_io_sel, x_pcr_sel, x_cl_sel}, xs[k]);
            check(x_we_out, |xs[k]);
            check(x_wdata_out, 8'h5A);
            check(x_rdata, (|xs[k]) ? {8'h00, xa[k][7:0] ^ 8'hA5} : 16'h0000);
        end
        sfr_wr(8'hFA, 8'h62);
        @(posedge ref_clk);
        x_paged <= 1'b1;
        x_ptr_reg <= 8'h34;
        #1;
        check(x_addr, 16'h6234);
        check(x_pcr_sel, 1'b1);
        check(x_region, 5'h02);
        $display("t_extended_data_space done");
    endtask : t_extended_data_space
    task automatic t_pwr;
        sfr_wr(8'h87, 8'h00);
        check({sfr_hit, sfr_rdata, debug_baud_double, cpu_power_down}, 11'h400);
        n = 0;
        while (mc_start !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (mc_start !== 1'b1 && n < 20);
        check(16'(n), 16'(mmd_pkg::STATES_PER_MC));
        // software keeps bit 0 clear, reserved bits must read back zero
        sfr_wr(8'h87, 8'hFE);
        check({sfr_rdata, debug_baud_double, cpu_power_down}, 10'h20B);
        repeat (8) @(posedge ref_clk);
        #1;
        check({clk_state, mc_start}, 7'h02);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check({debug_baud_double, cpu_power_down}, 2'h0);
        $display("t_pwr done");
    endtask : t_pwr
    task automatic t_rom;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            pc_addr <= (k == 0) ? 16'h9FFF : (k == 1) ? 16'hA000 : 16'h0000;
            #1;
            check(rom_sel, k != 1);
            check(rom_addr, pc_addr);
        end
        $display("t_rom done");
    endtask : t_rom
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        {id_req, id_indirect, id_we, x_req, x_paged, x_we, id_field, id_reg_val} = '0;
        {id_wdata, x_ptr_reg, x_wdata, data_pointer_reg, pc_addr} = '0;
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_internal_data_space();
        t_extended_data_space();
        t_pwr();
        t_rom();
        tally_and_finish();
    end
endmodule : mmd_decoder_tb
bind mmd_decoder mmd_decoder_assertions #(.ADDR_W(ADDR_W)) i_chk (.*);
